// >>> rtl/exec_unit_pkg.sv
package exec_unit_pkg;

  // ----------------------------------------------------------------
  // widths and fixed fields
  // ----------------------------------------------------------------
  localparam int unsigned DATA_WIDTH    = 32;
  localparam int unsigned SHAMT_WIDTH   = 5;
  localparam int unsigned REG_IDX_WIDTH = 5;
  localparam int unsigned TARGET_WIDTH  = 26;
  localparam int unsigned OFFSET_WIDTH  = 16;
  localparam int unsigned PC_TOP_BITS   = 4;
  localparam int unsigned INSTR_BYTES   = 4;
  localparam logic [4:0]  LINK_REG_IDX  = 5'd31;
  localparam logic [31:0] RESULT_RESET  = 32'h0000_0000;
  localparam logic [31:0] PC_RESET      = 32'h0000_0000;
  localparam int unsigned DIV_STEPS     = 32;

  // ----------------------------------------------------------------
  // operations
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    op_none,
    op_shift_left_logical_imm,
    op_shift_right_logical_imm,
    op_shift_right_arith_imm,
    op_shift_left_logical_var,
    op_shift_right_logical_var,
    op_shift_right_arith_var,
    op_multiply_signed,
    op_multiply_unsigned,
    op_divide_signed,
    op_divide_unsigned,
    op_move_from_high_result,
    op_move_from_low_result,
    op_move_to_high_result,
    op_move_to_low_result,
    op_absolute_jump,
    op_absolute_jump_link,
    op_register_jump,
    op_register_jump_link,
    op_branch,
    op_branch_link
  } op_type;

  typedef enum logic [1:0] {
    shift_left,
    shift_right_logical,
    shift_right_arith
  } shift_kind_type;

  // ----------------------------------------------------------------
  // request and answer carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    op_type      op;
    logic [31:0] first_source;
    logic [31:0] second_source;
    logic [4:0]  shift_amount;
    logic [4:0]  dest_idx;
    logic [25:0] jump_target;
    logic [15:0] branch_offset;
    logic        branch_taken;
  } exec_request_type;

  typedef struct packed {
    logic        write_enable;
    logic [4:0]  write_idx;
    logic [31:0] write_data;
  } reg_write_type;

  typedef struct packed {
    logic        redirect;
    logic [31:0] target;
  } redirect_type;

endpackage : exec_unit_pkg

// >>> rtl/barrel_shifter.sv
`timescale 1ns/1ps

module barrel_shifter
  import exec_unit_pkg::*;
(
  // operand and control
  input  wire logic [31:0]    value_in,
  input  wire logic [4:0]     amount_in,
  input  wire shift_kind_type kind_in,
  // result
  output logic [31:0]         result_out
);

  logic [31:0] stage [0:5];
  logic        fill;

  assign fill     = (kind_in == shift_right_arith) ? value_in[31] : 1'b0;
  assign stage[0] = value_in;

  // ----------------------------------------------------------------
  // log shifter, one stage per amount bit
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 5; i++) begin : g_stage
      localparam int unsigned D = 1 << i;
      always_comb begin
        if (!amount_in[i]) begin
          stage[i+1] = stage[i];
        end else if (kind_in == shift_left) begin
          stage[i+1] = {stage[i][31-D:0], {D{1'b0}}};
        end else begin
          stage[i+1] = {{D{fill}}, stage[i][31:D]};
        end
      end
    end
  endgenerate

  assign result_out = stage[5];

endmodule : barrel_shifter

// >>> rtl/seq_divider.sv
`timescale 1ns/1ps

module seq_divider
  import exec_unit_pkg::*;
(
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  // request
  input  wire logic        start_in,
  input  wire logic        signed_in,
  input  wire logic [31:0] dividend_in,
  input  wire logic [31:0] divisor_in,
  // answer
  output logic             busy_out,
  output logic             done_out,
  output logic [31:0]      quotient_out,
  output logic [31:0]      remainder_out
);

  logic [31:0] quot;
  logic [32:0] rem;
  logic [31:0] divisor_mag;
  logic        neg_quot;
  logic        neg_rem;
  logic [5:0]  count;
  logic [32:0] trial;
  logic [31:0] dividend_mag;

  // remainder takes the dividend's sign, quotient truncates toward zero
  assign dividend_mag = (signed_in && dividend_in[31]) ? (~dividend_in + 32'h0000_0001) : dividend_in;
  assign trial        = {rem[31:0], quot[31]} - {1'b0, divisor_mag};

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      busy_out    <= 1'b0;
      done_out    <= 1'b0;
      count       <= 6'd0;
      quot        <= 32'h0000_0000;
      rem         <= 33'h0_0000_0000;
      divisor_mag <= 32'h0000_0000;
      neg_quot    <= 1'b0;
      neg_rem     <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in && !busy_out) begin
        busy_out    <= 1'b1;
        count       <= 6'(DIV_STEPS);
        quot        <= dividend_mag;
        rem         <= 33'h0_0000_0000;
        divisor_mag <= (signed_in && divisor_in[31]) ? (~divisor_in + 32'h0000_0001) : divisor_in;
        neg_quot    <= signed_in && (dividend_in[31] ^ divisor_in[31]);
        neg_rem     <= signed_in && dividend_in[31];
      end else if (busy_out) begin
        if (trial[32]) begin
          rem  <= {rem[31:0], quot[31]};
          quot <= {quot[30:0], 1'b0};
        end else begin
          rem  <= trial;
          quot <= {quot[30:0], 1'b1};
        end
        count <= count - 6'd1;
        if (count == 6'd1) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end

  // divide by zero yields whatever the restoring loop leaves; software must avoid it
  assign quotient_out  = neg_quot ? (~quot + 32'h0000_0001) : quot;
  assign remainder_out = neg_rem ? (~rem[31:0] + 32'h0000_0001) : rem[31:0];

endmodule : seq_divider

// >>> rtl/shift_muldiv_jump_unit.sv
`timescale 1ns/1ps

// Summary of operation
// - immediate left shift, zero fill, 32-bit result
// - immediate logical right shift, zero fill
// - immediate arithmetic right shift replicates sign
// - variable shift amount from low five bits
// - variable logical right shift, zero fill
// - variable arithmetic right shift copies sign bit
// - multiply gives 64-bit product into high/low
// - divide: quotient low, remainder high
// - move-from copies high or low to register
// - move-to copies register into high or low
// - one delay slot always executes
// - absolute jump: delay-slot pc top four, target shifted
// - absolute jump-link writes return to r31
// - register jumps use full register address
// - branches use 16-bit pc-relative displacement
// - absolute jump-link and branch-and-link save return in r31; register jump-link saves it in dest_idx
// - branch target: delay slot plus shifted offset
module shift_muldiv_jump_unit
  import exec_unit_pkg::*;
(
  // clock and reset
  input  wire logic                           clock_in,
  input  wire logic                           rst_n_in,
  // issue side
  input  wire logic                           issue_valid_in,
  input  wire exec_unit_pkg::exec_request_type request_in,
  input  wire logic [31:0]                    pc_in,
  output logic                                issue_ready_out,
  // register file write port
  output exec_unit_pkg::reg_write_type        reg_write_out,
  // program counter redirect
  output exec_unit_pkg::redirect_type         redirect_out,
  // result registers and divider busy flag, visible for debug
  output logic [31:0]                         high_result_reg_out,
  output logic [31:0]                         low_result_reg_out,
  output logic                                divide_busy_out
);

  import exec_unit_pkg::*;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic           accept;
  logic [31:0]    high_result_reg;
  logic [31:0]    low_result_reg;
  logic [31:0]    shift_value;
  logic [4:0]     shift_amount;
  shift_kind_type shift_kind;
  logic [31:0]    shift_result;
  logic           is_shift;
  logic           div_busy;
  logic           div_done;
  logic [31:0]    div_quot;
  logic [31:0]    div_rem;
  logic           div_start;
  logic           div_signed;
  logic [63:0]    product;
  logic [31:0]    delay_slot_pc;
  logic [31:0]    return_pc;
  logic [31:0]    branch_disp;
  logic [31:0]    next_target;
  logic           next_redirect;

  // a new request waits while the divider iterates and in its done cycle, so a
  // multiply or move then is neither lost nor reads the stale result pair
  assign issue_ready_out = !(div_busy || div_done);
  assign accept          = issue_valid_in && issue_ready_out;

  // ----------------------------------------------------------------
  // shifter
  // ----------------------------------------------------------------
  always_comb begin
    shift_value  = request_in.second_source;
    shift_amount = request_in.shift_amount;
    shift_kind   = shift_left;
    is_shift     = 1'b1;
    case (request_in.op)
      op_shift_left_logical_imm: begin
        shift_kind = shift_left;
      end
      op_shift_right_logical_imm: begin
        shift_kind = shift_right_logical;
      end
      op_shift_right_arith_imm: begin
        shift_kind = shift_right_arith;
      end
      op_shift_left_logical_var: begin
        shift_amount = request_in.first_source[SHAMT_WIDTH-1:0];
        shift_kind   = shift_left;
      end
      op_shift_right_logical_var: begin
        shift_amount = request_in.first_source[SHAMT_WIDTH-1:0];
        shift_kind   = shift_right_logical;
      end
      op_shift_right_arith_var: begin
        shift_amount = request_in.first_source[SHAMT_WIDTH-1:0];
        shift_kind   = shift_right_arith;
      end
      default: begin
        is_shift = 1'b0;
      end
    endcase
  end

  barrel_shifter u_shifter (
    .value_in   (shift_value),
    .amount_in  (shift_amount),
    .kind_in    (shift_kind),
    .result_out (shift_result)
  );

  // ----------------------------------------------------------------
  // multiply and divide
  // ----------------------------------------------------------------
  // single-cycle multiply: trades area for never stalling issue
  always_comb begin
    if (request_in.op == op_multiply_signed) begin
      product = 64'($signed({{32{request_in.first_source[31]}}, request_in.first_source})
                  * $signed({{32{request_in.second_source[31]}}, request_in.second_source}));
    end else begin
      product = {32'h0000_0000, request_in.first_source}
              * {32'h0000_0000, request_in.second_source};
    end
  end

  assign div_start  = accept && (request_in.op == op_divide_signed || request_in.op == op_divide_unsigned);
  assign div_signed = (request_in.op == op_divide_signed);

  seq_divider u_divider (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_in),
    .start_in      (div_start),
    .signed_in     (div_signed),
    .dividend_in   (request_in.first_source),
    .divisor_in    (request_in.second_source),
    .busy_out      (div_busy),
    .done_out      (div_done),
    .quotient_out  (div_quot),
    .remainder_out (div_rem)
  );

  // ----------------------------------------------------------------
  // result registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      high_result_reg <= RESULT_RESET;
      low_result_reg  <= RESULT_RESET;
    end else if (div_done) begin
      low_result_reg  <= div_quot;
      high_result_reg <= div_rem;
    end else if (accept) begin
      case (request_in.op)
        op_multiply_signed, op_multiply_unsigned: begin
          high_result_reg <= product[63:32];
          low_result_reg  <= product[31:0];
        end
        op_move_to_high_result: begin
          high_result_reg <= request_in.first_source;
        end
        op_move_to_low_result: begin
          low_result_reg <= request_in.first_source;
        end
        default: begin
        end
      endcase
    end
  end

  assign high_result_reg_out = high_result_reg;
  assign low_result_reg_out  = low_result_reg;
  assign divide_busy_out     = div_busy;

  // ----------------------------------------------------------------
  // jump and branch addresses
  // ----------------------------------------------------------------
  // pc_in is the address of the jump itself; the next one always runs
  assign delay_slot_pc = pc_in + 32'(INSTR_BYTES);
  assign return_pc     = pc_in + 32'(2 * INSTR_BYTES);
  assign branch_disp   = {{14{request_in.branch_offset[15]}}, request_in.branch_offset, 2'b00};

  always_comb begin
    next_redirect = 1'b0;
    next_target   = PC_RESET;
    case (request_in.op)
      op_absolute_jump, op_absolute_jump_link: begin
        next_redirect = 1'b1;
        next_target   = {delay_slot_pc[31:28], request_in.jump_target, 2'b00};
      end
      op_register_jump, op_register_jump_link: begin
        next_redirect = 1'b1;
        next_target   = request_in.first_source;
      end
      op_branch, op_branch_link: begin
        next_redirect = request_in.branch_taken;
        next_target   = delay_slot_pc + branch_disp;
      end
      default: begin
      end
    endcase
  end

  // redirect is a one-cycle pulse; fetch already holds the delay slot
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      redirect_out <= '{redirect: 1'b0, target: PC_RESET};
    end else begin
      redirect_out.redirect <= accept && next_redirect;
      redirect_out.target   <= next_target;
    end
  end

  // ----------------------------------------------------------------
  // register file write-back
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      reg_write_out <= '{write_enable: 1'b0, write_idx: 5'd0, write_data: 32'h0000_0000};
    end else begin
      reg_write_out.write_enable <= 1'b0;
      reg_write_out.write_idx    <= request_in.dest_idx;
      reg_write_out.write_data   <= shift_result;
      if (accept) begin
        if (is_shift) begin
          reg_write_out.write_enable <= 1'b1;
        end
        case (request_in.op)
          op_move_from_high_result: begin
            reg_write_out.write_enable <= 1'b1;
            reg_write_out.write_data   <= high_result_reg;
          end
          op_move_from_low_result: begin
            reg_write_out.write_enable <= 1'b1;
            reg_write_out.write_data   <= low_result_reg;
          end
          op_absolute_jump_link, op_branch_link: begin
            reg_write_out.write_enable <= 1'b1;
            reg_write_out.write_idx    <= LINK_REG_IDX;
            reg_write_out.write_data   <= return_pc;
          end
          op_register_jump_link: begin
            reg_write_out.write_enable <= 1'b1;
            reg_write_out.write_data   <= return_pc;
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule : shift_muldiv_jump_unit

// >>> testbench/exec_unit_props.sv
`timescale 1ns/1ps

module exec_unit_checker
  import exec_unit_pkg::*;
(
  // clock and reset
  input wire logic                             clock_in,
  input wire logic                             rst_n_in,
  // issue side
  input wire logic                             issue_valid_in,
  input wire exec_unit_pkg::exec_request_type request_in,
  input wire logic [31:0]                      pc_in,
  input wire logic                             issue_ready_out,
  // answers
  input wire exec_unit_pkg::reg_write_type    reg_write_out,
  input wire exec_unit_pkg::redirect_type     redirect_out,
  input wire logic [31:0]                      high_result_reg_out,
  input wire logic [31:0]                      low_result_reg_out,
  input wire logic                             divide_busy_out
);
  // ----------------------------------------------------------------
  // previous cycle's request and whether it was taken
  // ----------------------------------------------------------------
  logic             took;
  exec_request_type lr;
  logic [31:0]      lpc;
  logic [31:0]      slot_pc;

  always_ff @(posedge clock_in) begin
    took <= rst_n_in && issue_valid_in && issue_ready_out;
    lr   <= request_in;
    lpc  <= pc_in;
  end

  assign slot_pc = lpc + 32'h0000_0004;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  // ----------------------------------------------------------------
  // answers one cycle after the take
  // ----------------------------------------------------------------
  sll_imm_a: assert property (took && lr.op == op_shift_left_logical_imm |-> reg_write_out.write_enable &&
    reg_write_out.write_data == lr.second_source << lr.shift_amount) else $error("immediate left shift wrong");
  shift_right_arith_var_var_a: assert property (took && lr.op == op_shift_right_arith_var |->
    reg_write_out.write_data == 32'($signed(lr.second_source) >>> lr.first_source[4:0]))
    else $error("variable arithmetic shift wrong");
  mul_signed_a: assert property (took && lr.op == op_multiply_signed |-> {high_result_reg_out,
    low_result_reg_out} == {{32{lr.first_source[31]}}, lr.first_source} * {{32{lr.second_source[31]}},
    lr.second_source}) else $error("signed product wrong");
  move_to_low_result_copy_a: assert property (took && lr.op == op_move_to_low_result |->
    low_result_reg_out == lr.first_source) else $error("move to low wrong");
  jal_link_a: assert property (took && lr.op == op_absolute_jump_link |-> redirect_out.redirect &&
    redirect_out.target == {slot_pc[31:28], lr.jump_target, 2'b00} && reg_write_out.write_idx == LINK_REG_IDX
    && reg_write_out.write_data == lpc + 32'h0000_0008) else $error("jump and link wrong");
  jr_target_a: assert property (took && lr.op == op_register_jump |-> redirect_out.redirect &&
    redirect_out.target == lr.first_source) else $error("register jump target wrong");
  branch_target_a: assert property (took && lr.op == op_branch && lr.branch_taken |->
    redirect_out.redirect && redirect_out.target == slot_pc + {{14{lr.branch_offset[15]}},
    lr.branch_offset, 2'b00}) else $error("branch target wrong");

  // ----------------------------------------------------------------
  // divide occupancy
  // ----------------------------------------------------------------
  div_busy_a: assert property (took && lr.op inside {op_divide_signed, op_divide_unsigned} |->
    divide_busy_out [*8]) else $error("divider not busy after start");
  ready_gate_a: assert property (divide_busy_out |-> !issue_ready_out ##1
    ($stable(high_result_reg_out) && $stable(low_result_reg_out))) else $error("ready or result change while dividing");
endmodule : exec_unit_checker

bind shift_muldiv_jump_unit exec_unit_checker u_checker (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .issue_valid_in(issue_valid_in), .request_in(request_in), .pc_in(pc_in), .issue_ready_out(issue_ready_out),
  .reg_write_out(reg_write_out), .redirect_out(redirect_out), .high_result_reg_out(high_result_reg_out),
  .low_result_reg_out(low_result_reg_out), .divide_busy_out(divide_busy_out));

// >>> testbench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  import exec_unit_pkg::*;

  logic             clock_in;
  logic             rst_n_in;
  logic             issue_valid_in;
  exec_request_type request_in;
  exec_request_type req;
  logic [31:0]      pc_in;
  logic             issue_ready_out;
  reg_write_type    reg_write_out;
  redirect_type     redirect_out;
  logic [31:0]      high_result_reg_out;
  logic [31:0]      low_result_reg_out;
  logic             divide_busy_out;
  int               fail_count;
  int               total_checks;

  shift_muldiv_jump_unit dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .issue_valid_in(issue_valid_in),
    .request_in(request_in), .pc_in(pc_in), .issue_ready_out(issue_ready_out), .reg_write_out(reg_write_out),
    .redirect_out(redirect_out), .high_result_reg_out(high_result_reg_out),
    .low_result_reg_out(low_result_reg_out), .divide_busy_out(divide_busy_out));

  always #12.5 clock_in = ~clock_in;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  // entered at a falling edge; valid stays up so calls can run back to back
  task automatic issue(input op_type op);
    req.op         = op;
    request_in     = req;
    issue_valid_in = 1'b1;
    @(posedge clock_in);
    @(negedge clock_in);
  endtask : issue

  task automatic idle();
    issue_valid_in = 1'b0;
    @(negedge clock_in);
  endtask : idle

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic shift_scenario();
    logic [31:0] v;
    logic [31:0] e;
    logic [4:0]  n;
    v = 32'h8000_0f01;
    req.second_source = v;
    req.dest_idx      = 5'h07;
    for (int i = 0; i < 3; i++) begin
      n = (i == 0) ? 5'h00 : (i == 1) ? 5'h01 : 5'h1f;
      for (int k = 0; k < 6; k++) begin
        // the unused distance source carries a different value to catch a swapped source
        req.shift_amount = (k < 3) ? n : ~n;
        req.first_source = {27'h7ff_ffff, (k < 3) ? ~n : n};
        case (k % 3)
          0: e = v << n;
          1: e = v >> n;
          default: e = $unsigned($signed(v) >>> n);
        endcase
        issue(op_type'(k + 1));
        check("shift_write", {reg_write_out.write_enable, reg_write_out.write_idx}, {1'b1, 5'h07});
        check("shift_data", reg_write_out.write_data, e);
      end
    end
    idle();
    check("write_pulse", reg_write_out.write_enable, 1'b0);
  endtask : shift_scenario

  task automatic div_run(input op_type op, input logic [31:0] a, b, q, r);
    int n;
    req.first_source  = a;
    req.second_source = b;
    issue(op);
    check("div_busy", {divide_busy_out, issue_ready_out}, 2'b10);
    // a move-to offered while busy must be ignored
    req.first_source = 32'h5a5a_5a5a;
    issue(op_move_to_low_result);
    idle();
    n = 0;
    while (divide_busy_out !== 1'b0 && n < 40) begin
      @(negedge clock_in);
      n++;
    end
    if (n == 40) begin
      fail_count++;
      end_of_test();
    end
    // done cycle: results land at the next edge, so issue still holds off
    check("div_done_stall", issue_ready_out, 1'b0);
    repeat (2) @(negedge clock_in);
    check("div_result", {high_result_reg_out, low_result_reg_out}, {r, q});
  endtask : div_run

  task automatic muldiv_scenario();
    logic [31:0] a;
    logic [31:0] b;
    a = 32'hffff_fffd;
    b = 32'h0000_0007;
    req.first_source  = a;
    req.second_source = b;
    issue(op_multiply_signed);
    check("mul_s", {high_result_reg_out, low_result_reg_out}, 64'hffff_ffff_ffff_ffeb);
    issue(op_multiply_unsigned);
    check("mul_u", {high_result_reg_out, low_result_reg_out}, 64'h0000_0006_ffff_ffeb);
    div_run(op_divide_signed, 32'hffff_fff9, 32'h0000_0002, 32'hffff_fffd, 32'hffff_ffff);
    div_run(op_divide_unsigned, 32'h0000_0064, 32'h0000_0007, 32'h0000_000e, 32'h0000_0002);
  endtask : muldiv_scenario

  task automatic move_scenario();
    req.dest_idx     = 5'h0c;
    req.first_source = 32'h1234_5678;
    issue(op_move_to_high_result);
    req.first_source = 32'h9abc_def0;
    issue(op_move_to_low_result);
    check("move_to", {high_result_reg_out, low_result_reg_out}, 64'h1234_5678_9abc_def0);
    issue(op_move_from_high_result);
    check("mfh", {reg_write_out.write_enable, reg_write_out.write_idx, reg_write_out.write_data},
      {1'b1, 5'h0c, 32'h1234_5678});
    issue(op_move_from_low_result);
    check("mfl", reg_write_out.write_data, 32'h9abc_def0);
    idle();
  endtask : move_scenario

  task automatic jump_scenario();
    logic [31:0] p;
    p = 32'h3fff_fffc;
    pc_in = p;
    req.jump_target   = 26'h2ab_cdef;
    req.first_source  = 32'h8000_1234;
    req.dest_idx      = 5'h09;
    req.branch_offset = 16'hfffe;
    req.branch_taken  = 1'b1;
    issue(op_absolute_jump);
    check("j", {redirect_out.redirect, redirect_out.target}, {1'b1, 4'h4, 26'h2ab_cdef, 2'b00});
    issue(op_absolute_jump_link);
    check("jal", {reg_write_out.write_idx, reg_write_out.write_data}, {LINK_REG_IDX, p + 32'h0000_0008});
    // the delay-slot instruction follows with no gap
    req.second_source = 32'h0000_0001;
    req.shift_amount  = 5'h04;
    req.dest_idx      = 5'h03;
    pc_in = p + 32'h0000_0004;
    issue(op_shift_left_logical_imm);
    check("slot", {redirect_out.redirect, reg_write_out.write_data}, {1'b0, 32'h0000_0010});
    pc_in = p;
    req.dest_idx = 5'h09;
    issue(op_register_jump);
    check("jr", {redirect_out.redirect, redirect_out.target}, {1'b1, 32'h8000_1234});
    issue(op_register_jump_link);
    check("register_jump_link_t", redirect_out.target, 32'h8000_1234);
    check("register_jump_link_w", {reg_write_out.write_idx, reg_write_out.write_data}, {5'h09, p + 32'h0000_0008});
    pc_in = 32'h0000_1000;
    issue(op_branch);
    check("br_back", {redirect_out.redirect, redirect_out.target}, {1'b1, 32'h0000_0ffc});
    req.branch_taken = 1'b0;
    issue(op_branch_link);
    check("bal_not", {redirect_out.redirect, reg_write_out.write_enable}, 2'b01);
    check("bal_link", {reg_write_out.write_idx, reg_write_out.write_data}, {LINK_REG_IDX, 32'h0000_1008});
    req.branch_taken  = 1'b1;
    req.branch_offset = 16'h0003;
    issue(op_branch_link);
    check("bal_fwd", {redirect_out.redirect, redirect_out.target}, {1'b1, 32'h0000_1010});
    idle();
    check("redirect_pulse", redirect_out.redirect, 1'b0);
  endtask : jump_scenario

  initial begin
    clock_in       = 1'b0;
    rst_n_in       = 1'b0;
    issue_valid_in = 1'b0;
    request_in     = '0;
    req            = '0;
    pc_in          = 32'h0000_0000;
    fail_count     = 0;
    total_checks   = 0;
    repeat (10) @(negedge clock_in);
    rst_n_in = 1'b1;
    shift_scenario();
    muldiv_scenario();
    move_scenario();
    jump_scenario();
    end_of_test();
  end
endmodule : tb_top
